// ==== src/scss_pkg.sv ====
`default_nettype none
package scss_pkg;
  // sequencer interval lengths, counted in system clocks
  localparam int unsigned INTERVAL_CYCLES = 32'h0000_0040;
  // logic supply settling delay before requests are honoured
  localparam int unsigned SETTLE_TIME_MS = 32'h0000_000A;
  localparam int unsigned CLK_RATE_KHZ = 32'h0001_E848;
  localparam int unsigned SETTLE_CYCLES = SETTLE_TIME_MS * CLK_RATE_KHZ;
  // divider select encodings {select_a, select_b}
  localparam logic [1:0] DIV_BY_8 = 2'h0;
  localparam logic [1:0] DIV_BY_4 = 2'h1;
  localparam logic [1:0] DIV_BY_1 = 2'h2;
  localparam logic [1:0] DIV_BY_2 = 2'h3;
  localparam logic [2:0] DIV_CNT_ZERO = 3'h0;
  typedef enum {ST_IDLE, ST_RAMP, ST_WAIT_RST, ST_RX_ON, ST_ACTIVE, ST_DEACT} scss_state_t;
  typedef enum {DIR_IDLE, DIR_CARD_IN, DIR_HOST_IN} scss_dir_t;
endpackage
`default_nettype wire

// ==== src/scss_clkdiv.sv ====
`timescale 1ns/1ps
`default_nettype none
// card clock divider; output comes from a flip-flop
module scss_clkdiv (
  input wire logic clk, // system clock
  input wire logic arst_n, // async reset, active low
  input wire logic enable, // run the card clock
  input wire logic [1:0] sel, // divider select
  output logic clk_out // divided clock
);
  logic [2:0] cnt_q;
  logic out_q;
  wire logic [2:0] cnt_d = cnt_q + 3'h1;
  // selected tap; by-one toggles every edge, so it runs at half rate in this domain
  wire logic tap = (sel == scss_pkg::DIV_BY_8) ? cnt_q[2] :
                   (sel == scss_pkg::DIV_BY_4) ? cnt_q[1] :
                   (sel == scss_pkg::DIV_BY_2) ? cnt_q[0] : ~out_q;
  // counter held at zero and output parks low while disabled
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= scss_pkg::DIV_CNT_ZERO;
      out_q <= 1'b0;
    end else begin
      cnt_q <= enable ? cnt_d : scss_pkg::DIV_CNT_ZERO;
      out_q <= enable & tap;
    end
  end
  assign clk_out = out_q;
endmodule
`default_nettype wire

// ==== src/scss_top.sv ====
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// [RULE_01] check card supply after first interval
// [RULE_02] reset high: clock starts at reset fall
// [RULE_03] then card reset copies host reset
// [RULE_04] deactivate on release or any fault
// [RULE_05] deactivate: reset, clock, data, supply
// [RULE_06] outside session alert shows card presence
// [RULE_07] outside session faults are ignored
// [RULE_08] in session fault drops alert, deactivates
// [RULE_09] card data low until reception on
// [RULE_10] host data high after reset
// [RULE_11] first falling edge picks input line
// [RULE_12] input rising edge returns lines idle
// [RULE_13] ignore requests during settling delay
// [RULE_14] falling request edge, card, supply ok
// [RULE_15] reset low: reception t2, clock t3
// [RULE_16] card clock divided by 1,2,4,8; by-one select gives half rate, same as by-two
// [RULE_17] interval lengths are parameters
// [RULE_18] deactivation completes; new edge needed
module scss_top #(
  parameter int unsigned INTERVAL = scss_pkg::INTERVAL_CYCLES, // RULE_17 interval length
  parameter int unsigned SETTLE = scss_pkg::SETTLE_CYCLES // settling delay in cycles
) (
  input wire logic SYS_CLK, // system clock, 125 MHz
  input wire logic ARST_N, // power-on reset, active low
  input wire logic ACTIVATION_REQUEST_N, // host activation request, active low
  input wire logic HOST_RESET_IN, // host card reset control
  input wire logic CARD_PRESENT_IN, // card present, high
  input wire logic SUPPLY_LEVEL_SELECT, // card supply level, high for upper level
  input wire logic CLOCK_DIVIDE_SELECT_A, // divider select a
  input wire logic CLOCK_DIVIDE_SELECT_B, // divider select b
  input wire logic LOGIC_SUPPLY_OK, // logic supply above fault threshold
  input wire logic CARD_SUPPLY_VALID, // card supply reached level
  input wire logic OVER_CURRENT, // card over-current fault
  output logic CARD_SUPPLY_EN, // card supply on
  output logic CARD_SUPPLY_LEVEL, // registered supply level
  output logic CARD_RESET, // card reset
  output logic CARD_CLOCK, // card clock
  output logic ALERT_N_OE, // alert open-drain pull low
  input wire logic CARD_DATA_I, // card data line in
  output logic CARD_DATA_O, // card data line out
  output logic CARD_DATA_OE, // card data drive enable
  input wire logic HOST_DATA_LINE_I, // host data line in
  output logic HOST_DATA_LINE_O, // host data line out
  output logic HOST_DATA_LINE_OE // host data drive enable
);
  scss_pkg::scss_state_t st_q, st_d;
  scss_pkg::scss_dir_t dir_q, dir_d;
  logic [31:0] tmr_q;
  logic [31:0] settle_q;
  logic [2:0] dstep_q;
  logic req_q, host_reset_in_q, cdata_q, hdata_q, fault_alert_q, supply_q, level_q;
  logic rx_q, clk_en_q, rst_copy_q;

  // decode of edges and conditions
  wire logic req_fall = req_q & ~ACTIVATION_REQUEST_N;
  wire logic rst_fall = host_reset_in_q & ~HOST_RESET_IN;
  wire logic settled = (settle_q == 32'h0000_0000);
  wire logic tmr_done = (tmr_q == INTERVAL - 1);
  wire logic in_session = (st_q != scss_pkg::ST_IDLE) && (st_q != scss_pkg::ST_DEACT);
  wire logic any_fault = ~CARD_PRESENT_IN | ~LOGIC_SUPPLY_OK | OVER_CURRENT; // RULE_04
  wire logic supply_bad = (st_q == scss_pkg::ST_RAMP) & tmr_done & ~CARD_SUPPLY_VALID; // RULE_01
  wire logic session_fault = in_session & (any_fault | supply_bad | (st_q != scss_pkg::ST_RAMP & ~CARD_SUPPLY_VALID));
  wire logic start_ok = req_fall & CARD_PRESENT_IN & LOGIC_SUPPLY_OK & settled; // RULE_13 RULE_14
  wire logic go_deact = in_session & (ACTIVATION_REQUEST_N | session_fault); // RULE_04 RULE_08
  wire logic card_fall = cdata_q & ~CARD_DATA_I;
  wire logic host_fall = hdata_q & ~HOST_DATA_LINE_I;

  // activation / deactivation sequencer
  always_comb begin
    st_d = st_q;
    case (st_q)
      scss_pkg::ST_IDLE: if (start_ok) st_d = scss_pkg::ST_RAMP; // RULE_18
      scss_pkg::ST_RAMP: if (tmr_done) st_d = HOST_RESET_IN ? scss_pkg::ST_WAIT_RST : scss_pkg::ST_RX_ON;
      scss_pkg::ST_WAIT_RST: if (rst_fall) st_d = scss_pkg::ST_ACTIVE; // RULE_02
      scss_pkg::ST_RX_ON: if (tmr_done) st_d = scss_pkg::ST_ACTIVE; // RULE_15
      scss_pkg::ST_ACTIVE: st_d = scss_pkg::ST_ACTIVE;
      scss_pkg::ST_DEACT: if (tmr_done && dstep_q == 3'h3) st_d = scss_pkg::ST_IDLE; // RULE_18
      default: st_d = scss_pkg::ST_IDLE;
    endcase
    if (go_deact) st_d = scss_pkg::ST_DEACT;
  end

  // data direction arbiter; card line wins a same-cycle tie
  always_comb begin
    dir_d = dir_q;
    case (dir_q)
      scss_pkg::DIR_IDLE: if (card_fall) dir_d = scss_pkg::DIR_CARD_IN; // RULE_11
        else if (host_fall) dir_d = scss_pkg::DIR_HOST_IN;
      scss_pkg::DIR_CARD_IN: if (CARD_DATA_I & ~cdata_q) dir_d = scss_pkg::DIR_IDLE; // RULE_12
      scss_pkg::DIR_HOST_IN: if (HOST_DATA_LINE_I & ~hdata_q) dir_d = scss_pkg::DIR_IDLE; // RULE_12
      default: dir_d = scss_pkg::DIR_IDLE;
    endcase
    if (!rx_q) dir_d = scss_pkg::DIR_IDLE;
  end

  // input sampling and settle counter
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      req_q <= 1'b1;
      host_reset_in_q <= 1'b0;
      cdata_q <= 1'b1;
      hdata_q <= 1'b1;
      settle_q <= 32'h0000_0000;
    end else begin
      req_q <= ACTIVATION_REQUEST_N;
      host_reset_in_q <= HOST_RESET_IN;
      cdata_q <= CARD_DATA_I;
      hdata_q <= HOST_DATA_LINE_I;
      // restart the settle delay whenever the logic supply drops
      if (!LOGIC_SUPPLY_OK) settle_q <= SETTLE; // RULE_13
      else if (!settled) settle_q <= settle_q - 32'h0000_0001;
    end
  end

  // state, interval timer and deactivation step
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_q <= scss_pkg::ST_IDLE;
      dir_q <= scss_pkg::DIR_IDLE;
      tmr_q <= 32'h0000_0000;
      dstep_q <= 3'h0;
    end else begin
      st_q <= st_d;
      dir_q <= dir_d;
      tmr_q <= (st_d != st_q || tmr_done) ? 32'h0000_0000 : tmr_q + 32'h0000_0001;
      if (st_d == scss_pkg::ST_DEACT && st_q != scss_pkg::ST_DEACT) dstep_q <= 3'h0;
      else if (st_q == scss_pkg::ST_DEACT && tmr_done) dstep_q <= dstep_q + 3'h1; // RULE_05
    end
  end

  // card-side controls; deactivation drops one per interval
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      supply_q <= 1'b0;
      level_q <= 1'b0;
      rx_q <= 1'b0;
      clk_en_q <= 1'b0;
      rst_copy_q <= 1'b0;
      fault_alert_q <= 1'b0;
    end else begin
      if (st_q == scss_pkg::ST_IDLE && start_ok) begin
        supply_q <= 1'b1;
        level_q <= SUPPLY_LEVEL_SELECT;
        fault_alert_q <= 1'b0;
      end
      if (st_q == scss_pkg::ST_RAMP && tmr_done && !HOST_RESET_IN) rx_q <= 1'b1; // RULE_15
      if (st_q == scss_pkg::ST_WAIT_RST && rst_fall) begin
        rx_q <= 1'b1;
        clk_en_q <= 1'b1; // RULE_02
        rst_copy_q <= 1'b1; // RULE_03
      end
      if (st_q == scss_pkg::ST_RX_ON && tmr_done) begin
        clk_en_q <= 1'b1; // RULE_15
        rst_copy_q <= 1'b1;
      end
      if (go_deact && session_fault) fault_alert_q <= 1'b1; // RULE_08
      if (supply_bad) supply_q <= 1'b0; // RULE_01
      if (st_q == scss_pkg::ST_DEACT && tmr_done) begin
        case (dstep_q)
          3'h0: rst_copy_q <= 1'b0; // RULE_05
          3'h1: clk_en_q <= 1'b0;
          3'h2: rx_q <= 1'b0;
          default: supply_q <= 1'b0;
        endcase
      end
      if (ACTIVATION_REQUEST_N && st_q == scss_pkg::ST_IDLE) fault_alert_q <= 1'b0;
    end
  end

  // card clock divider
  scss_clkdiv u_div (
    .clk(SYS_CLK),
    .arst_n(ARST_N),
    .enable(clk_en_q),
    .sel({CLOCK_DIVIDE_SELECT_A, CLOCK_DIVIDE_SELECT_B}), // RULE_16
    .clk_out(CARD_CLOCK)
  );

  // outputs; alert only reflects presence while no request is held
  wire logic outside = ACTIVATION_REQUEST_N & (st_q == scss_pkg::ST_IDLE);
  assign ALERT_N_OE = outside ? ~CARD_PRESENT_IN : (fault_alert_q | session_fault); // RULE_06 RULE_07 RULE_08
  assign CARD_SUPPLY_EN = supply_q;
  assign CARD_SUPPLY_LEVEL = level_q;
  assign CARD_RESET = rst_copy_q & HOST_RESET_IN; // RULE_03
  // card line low without reception; host line drives high idle
  assign CARD_DATA_O = rx_q & (dir_q == scss_pkg::DIR_HOST_IN ? hdata_q : 1'b1); // RULE_09 RULE_11
  assign CARD_DATA_OE = ~rx_q | (dir_q != scss_pkg::DIR_CARD_IN);
  assign HOST_DATA_LINE_O = (dir_q == scss_pkg::DIR_CARD_IN) ? cdata_q : 1'b1; // RULE_10
  assign HOST_DATA_LINE_OE = (dir_q != scss_pkg::DIR_HOST_IN);

  // assertions
  deact_order_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // RULE_05
    (st_q == scss_pkg::ST_DEACT && dstep_q == 3'h2 && tmr_done) |=> (!rx_q && !clk_en_q && !rst_copy_q))
    else $error("deactivation order broken");
  supply_check_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // RULE_01
    supply_bad |=> (!supply_q && ALERT_N_OE))
    else $error("bad supply not shut off");
  host_idle_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // RULE_10
    (dir_q == scss_pkg::DIR_IDLE) |-> (HOST_DATA_LINE_O && HOST_DATA_LINE_OE))
    else $error("host line not idle high");
  card_low_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // RULE_09
    !rx_q |-> (CARD_DATA_OE && !CARD_DATA_O))
    else $error("card line not held low");
  presence_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // RULE_06
    outside |-> (ALERT_N_OE == !CARD_PRESENT_IN))
    else $error("alert does not show presence");
  fault_deact_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // RULE_08
    (in_session && session_fault) |-> (ALERT_N_OE ##1 st_q == scss_pkg::ST_DEACT))
    else $error("fault not handled");
  settle_block_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // RULE_13
    (st_q == scss_pkg::ST_IDLE && !settled) |=> st_q != scss_pkg::ST_RAMP)
    else $error("activation during settle");
  rst_clock_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // RULE_02
    (st_q == scss_pkg::ST_WAIT_RST && !go_deact && rst_fall) |=> clk_en_q)
    else $error("clock not started at reset fall");
  return_idle_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // RULE_12
    (dir_q == scss_pkg::DIR_CARD_IN && CARD_DATA_I && !cdata_q) |=> dir_q == scss_pkg::DIR_IDLE)
    else $error("direction not released");
endmodule
`default_nettype wire

// ==== test/scss_far_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// host and card seen from the pins: open-drain data wires, card supply
module scss_far_model (
  input wire logic clk, // system clock
  input wire logic supply_en, // card supply on
  input wire logic sup_bad, // card supply fails to come up
  input wire logic card_o, // device card data out
  input wire logic card_oe, // device card data enable
  input wire logic card_low, // card pulls its line low
  input wire logic host_o, // device host data out
  input wire logic host_oe, // device host data enable
  input wire logic host_low, // host pulls its line low
  output logic supply_valid, // card supply reached level
  output logic card_line, // card data wire level
  output logic host_line // host data wire level
);
  logic en_q;
  // wired-and with pull-up: a released wire reads high, never a stale value
  assign card_line = (card_oe ? card_o : 1'b1) & ~card_low;
  assign host_line = (host_oe ? host_o : 1'b1) & ~host_low;
  // supply needs one clock to rise but drops at once when switched off
  assign supply_valid = supply_en & en_q & ~sup_bad;
  always_ff @(posedge clk) begin
    en_q <= supply_en;
  end
endmodule
`default_nettype wire

// ==== test/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int IV = 4;
  logic clk = 0, arst_n = 0, req = 1, hr = 0, card_present_in = 1, da = 1, db = 0, lok = 1, oc = 0, cl = 0, hl = 0, bad = 0;
  logic lsel = 1;
  wire logic sv, sup, lvl, crst, cclk, alert, cdo, cdoe, hdo, hdoe, card_line, host_line;
  int fail_count = 0, n_compared = 0, cycles = 0;
  // by-one runs at half rate in one clock domain, so it counts like by-two
  int dv [4] = '{8, 4, 2, 2};
  always #4 clk = ~clk;
  scss_top #(.INTERVAL(IV), .SETTLE(10)) dut (.SYS_CLK(clk), .ARST_N(arst_n), .ACTIVATION_REQUEST_N(req),
    .HOST_RESET_IN(hr), .CARD_PRESENT_IN(card_present_in), .SUPPLY_LEVEL_SELECT(lsel), .CLOCK_DIVIDE_SELECT_A(da),
    .CLOCK_DIVIDE_SELECT_B(db), .LOGIC_SUPPLY_OK(lok), .CARD_SUPPLY_VALID(sv), .OVER_CURRENT(oc),
    .CARD_SUPPLY_EN(sup), .CARD_SUPPLY_LEVEL(lvl), .CARD_RESET(crst), .CARD_CLOCK(cclk), .ALERT_N_OE(alert),
    .CARD_DATA_I(card_line), .CARD_DATA_O(cdo), .CARD_DATA_OE(cdoe), .HOST_DATA_LINE_I(host_line),
    .HOST_DATA_LINE_O(hdo), .HOST_DATA_LINE_OE(hdoe));
  scss_far_model far (.clk(clk), .supply_en(sup), .sup_bad(bad), .card_o(cdo), .card_oe(cdoe), .card_low(cl),
    .host_o(hdo), .host_oe(hdoe), .host_low(hl), .supply_valid(sv), .card_line(card_line), .host_line(host_line));
  task stop_test();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // inputs always move 1 ns after the edge, away from sampling
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // a hang would stall every check, so cap the whole run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      fail_count++;
      stop_test();
    end
  end
  task act(input logic r);
    hr = r;
    req = 0;
    for (int i = 0; i < 4 && sup !== 1'b1; i++) cyc(1);
    chk(sup, 1);
    chk(lvl, lsel);
    chk(card_line, 0);
  endtask
  task deact();
    int tr, td, ts, hc, hb;
    tr = -1;
    td = -1;
    ts = -1;
    hc = 0;
    hb = 0;
    req = 1;
    for (int i = 0; i < 8 * IV; i++) begin
      cyc(1);
      if (tr < 0 && !crst) tr = i;
      if (td < 0 && !card_line) td = i;
      if (ts < 0 && !sup) ts = i;
      // clock must keep running for the interval after reset drops
      if (tr >= 0 && i < tr + IV) hb += cclk;
      if (tr >= 0 && i > tr + IV + 1) hc += cclk;
    end
    chk(tr, IV);
    chk(hb != 0, 1);
    chk(td - tr, 2 * IV);
    chk(ts - td, IV);
    chk(hc, 0);
  endtask
  task t_outside();
    oc = 1;
    lok = 0;
    cyc(6);
    chk(alert, 0);
    chk(sup, 0);
    oc = 0;
    lok = 1;
    card_present_in = 0;
    cyc(2);
    chk(alert, 1);
    card_present_in = 1;
    cyc(2);
    chk(alert, 0);
  endtask
  // settle guard, reset-low activation, divider, data direction, release
  task t_session();
    int n;
    logic p;
    lok = 0;
    cyc(1);
    lok = 1;
    req = 0;
    cyc(5);
    chk(sup, 0);
    req = 1;
    cyc(12);
    act(0);
    cyc(3 * IV + 4);
    chk(card_line, 1);
    chk(crst, 0);
    for (int i = 0; i < 4; i++) begin
      {da, db} = i[1:0];
      cyc(20);
      n = 0;
      repeat (32) begin
        p = cclk;
        cyc(1);
        if (!p && cclk) n++;
      end
      chk(n, 32 / dv[i]);
    end
    {da, db} = 2'b10;
    cl = 1;
    cyc(3);
    chk(host_line, 0);
    cl = 0;
    cyc(3);
    chk(host_line, 1);
    chk(card_line, 1);
    hl = 1;
    cyc(3);
    chk(card_line, 0);
    hl = 0;
    cyc(3);
    chk(card_line, 1);
    hr = 1;
    cyc(2);
    chk(crst, 1);
    deact();
  endtask
  task t_fault();
    lsel = 0;
    act(0);
    cyc(3 * IV + 4);
    oc = 1;
    cyc(1);
    chk(alert, 1);
    cyc(5 * IV + 4);
    chk(sup, 0);
    oc = 0;
    cyc(6);
    chk(sup, 0);
    req = 1;
    cyc(3);
    chk(alert, 0);
  endtask
  task t_rst_high();
    int hi;
    lsel = 1;
    act(1);
    hi = 0;
    repeat (3 * IV + 4) begin
      cyc(1);
      hi += cclk;
    end
    chk(hi, 0);
    chk(crst, 0);
    hr = 0;
    hi = 0;
    repeat (8) begin
      cyc(1);
      hi += cclk;
    end
    chk(hi != 0, 1);
    hr = 1;
    cyc(1);
    chk(crst, 1);
    card_present_in = 0;
    cyc(1);
    chk(alert, 1);
    cyc(5 * IV + 4);
    chk(sup, 0);
    card_present_in = 1;
    req = 1;
    cyc(3);
  endtask
  task t_bad();
    bad = 1;
    act(0);
    cyc(IV + 3);
    chk(alert, 1);
    chk(sup, 0);
    bad = 0;
    req = 1;
    // the fault stays reported until every deactivation step has run
    cyc(4 * IV + 3);
    chk(alert, 0);
  endtask
  initial begin
    cyc(2);
    chk(cdoe, 1);
    chk(cdo, 0);
    chk(hdoe, 1);
    chk(hdo, 1);
    arst_n = 1;
    t_outside();
    t_session();
    t_fault();
    t_rst_high();
    t_bad();
    stop_test();
  end
endmodule
`default_nettype wire
